// ---- hw/pxp_top.sv ----
// Pixel level pipeline: gain, black offset, gamma and lookup on luminance.
// Assumes a Wishbone classic master on clk and a valid/ready pixel stream.
//
// The implementer's own choices: the register addresses and register access over Wishbone.
`timescale 1ns/1ns
module pxp_top
  import pxp_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  input  wire logic        pixInValid,
  output logic             pixInReady,
  input  wire logic [9:0]  pixInData,
  input  wire logic        pixInLast,
  output logic             pixOutValid,
  input  wire logic        pixOutReady,
  output logic [9:0]       pixOutData
);
  typedef struct packed {
    logic               ack;
    logic [31:0]        rdat;
    logic               autoMode;
    logic               lutEn;
    logic [15:0]        gainCode;
    logic [6:0]         gainIdx;
    logic [15:0]        blackCode;
    logic signed [10:0] blackLsb;
    logic [15:0]        gammaCode;
    logic [3:0]         gammaIdx;
    logic [9:0]         lutIdx;
    logic [9:0]         lutVal;
    logic [9:0]         autoTgt;
    logic [6:0]         autoIdx;
    logic signed [23:0] balance;
    logic               inRdy;
    logic               holdV;
    logic               holdLast;
    logic [9:0]         holdPix;
    logic               s1V;
    logic [9:0]         s1Pix;
    logic               s2V;
    logic [9:0]         s2Pix;
    logic               s3V;
    logic [9:0]         s3Pix;
    logic               s4V;
    logic               s4Use;
    logic [9:0]         s4Pix;
  } pxpState_t;
  pxpState_t   st_q;
  pxpState_t   st_d;
  logic [1:0]  rstSync_q;
  logic        rstSync_n;
  logic [9:0]  lutMem [LUT_DEPTH];
  logic [9:0]  lutRd_q;
  logic [11:0] gainRom [GAIN_IDX_MAX+1];
  logic [10:0] gammaRom [GAMMA_N][SEGS+1];
  logic        fifoRdy;
  logic [9:0]  s4Out;
  logic        adv;
  logic        wr;
  logic        lutWr;
  logic        srcV;
  logic        srcLast;
  logic [9:0]  srcPix;
  logic [6:0]  appliedIdx;
  logic [9:0]  gained;
  logic        autoStep;
  // Every assertion samples on clk and rests while the internal reset holds
  default clocking @(posedge clk); endclocking
  default disable iff (!rstSync_n);

  // ----------------------------------------
  // Reset release through two flip-flops
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rstSync_q <= 2'b00;
    end else begin
      rstSync_q <= {rstSync_q[0], 1'b1};
    end
  end
  assign rstSync_n = rstSync_q[1];

  // ----------------------------------------
  // Constant curves, folded at elaboration
  // ----------------------------------------
  // Gain factor in Q8 for every quarter decibel
  for (genvar g = 0; g <= GAIN_IDX_MAX; g++) begin : gGain
    localparam real DB = g * GAIN_STEP / CENTI;
    assign gainRom[g] = 12'(int'((2.0 ** GAIN_FRAC) * (10.0 ** (DB / DB_PER_POW))));
  end
  // Point SEGS sits at 1024 so exponent 1.00 is an exact identity
  for (genvar c = 0; c < GAMMA_N; c++) begin : gCurve
    for (genvar k = 0; k <= SEGS; k++) begin : gPt
      localparam real GV = (GAMMA_MIN + c * GAMMA_STEP) / CENTI;
      localparam real XN = (k * (2.0 ** SEG_BITS)) / PIX_MAX;
      assign gammaRom[c][k] = 11'(int'(PIX_MAX * (XN ** GV)));
    end
  end
  // Byte-lane merge for the 16-bit settings
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction
  // Saturate a signed setting into its allowed span
  function automatic logic [15:0] sat16(input int v, input int lo, input int hi);
    sat16 = 16'((v < lo) ? lo : ((v > hi) ? hi : v));
  endfunction

  // ----------------------------------------
  // Pipeline steering
  // ----------------------------------------
  // Stall everything when the last stage cannot empty into the FIFO
  assign adv        = !st_q.s4V || fifoRdy;
  assign srcV       = st_q.holdV || (pixInValid && st_q.inRdy);
  assign srcPix     = st_q.holdV ? st_q.holdPix : pixInData;
  assign srcLast    = st_q.holdV ? st_q.holdLast : pixInLast;
  assign appliedIdx = st_q.autoMode ? st_q.autoIdx : st_q.gainIdx;
  assign autoStep   = adv && srcV && srcLast && st_q.autoMode;
  assign wr         = cyc_i && stb_i && we_i && !st_q.ack;
  assign lutWr      = wr && (adr_i == REG_LUT_VAL);
  assign s4Out      = st_q.s4Use ? lutRd_q : st_q.s4Pix;
  // Gain multiply with saturation at full scale
  always_comb begin
    logic [21:0] prod;
    prod   = srcPix * gainRom[appliedIdx];
    gained = (prod[21:GAIN_FRAC] > 14'(PIX_MAX)) ? PIX_MAX : prod[GAIN_FRAC+9:GAIN_FRAC];
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic signed [11:0] offs;
    logic [5:0]         seg;
    logic [10:0]        lo;
    logic [10:0]        hi;
    logic [14:0]        interp;
    offs   = '0;
    seg    = '0;
    lo     = '0;
    hi     = '0;
    interp = '0;
    st_d   = st_q;
    // Bus answer: one wait state, ack dropped in the cycle after it
    st_d.ack  = cyc_i && stb_i && !st_q.ack;
    st_d.rdat = '0;
    if (cyc_i && stb_i && !we_i && !st_q.ack) begin
      case (adr_i)
        REG_CTRL:    st_d.rdat = 32'({st_q.lutEn, st_q.autoMode});
        REG_GAIN:    st_d.rdat = 32'(st_q.gainCode);
        REG_BLACK:   st_d.rdat = {{16{st_q.blackCode[15]}}, st_q.blackCode};
        REG_GAMMA:   st_d.rdat = 32'(st_q.gammaCode);
        REG_LUT_IDX: st_d.rdat = 32'(st_q.lutIdx);
        REG_LUT_VAL: st_d.rdat = 32'(st_q.lutVal);
        REG_COMP: begin
          // Fixed answers; writes here are dropped
          st_d.rdat[COMP_GAIN_POS +: 4] = COMP_LUMA;
          st_d.rdat[COMP_OFFS_POS +: 4] = COMP_LUMA;
          st_d.rdat[COMP_LUT_POS  +: 4] = COMP_LUMA;
        end
        REG_STATUS: begin
          st_d.rdat[6:0]           = appliedIdx;
          st_d.rdat[STAT_AUTO_BIT] = st_q.autoMode;
        end
        REG_AUTO:    st_d.rdat = 32'(st_q.autoTgt);
        default:     st_d.rdat = '0;
      endcase
    end
    // Register writes; out-of-span values saturate to the nearest bound, except REG_AUTO, which keeps only the low 10 bits
    if (wr) begin
      case (adr_i)
        REG_CTRL: if (sel_i[0]) begin
          st_d.autoMode = dat_i[CTRL_AUTO_BIT];
          st_d.lutEn    = dat_i[CTRL_LUT_BIT];
        end
        REG_GAIN: st_d.gainCode = sat16(int'(merge16(st_q.gainCode, dat_i, sel_i)), 0,
                                        int'(GAIN_MAX));
        REG_BLACK: st_d.blackCode = sat16(int'($signed(merge16(st_q.blackCode, dat_i,
                                          sel_i))), BLACK_MIN, BLACK_MAX);
        REG_GAMMA: st_d.gammaCode = sat16(int'(merge16(st_q.gammaCode, dat_i, sel_i)),
                                          GAMMA_MIN, GAMMA_MAX);
        REG_LUT_IDX: st_d.lutIdx = 10'(sat16(int'(merge16(16'(st_q.lutIdx), dat_i, sel_i)),
                                             0, int'(PIX_MAX)));
        REG_LUT_VAL: st_d.lutVal = 10'(sat16(int'(merge16(16'(st_q.lutVal), dat_i, sel_i)),
                                             0, int'(PIX_MAX)));
        REG_AUTO: st_d.autoTgt = 10'(merge16(16'(st_q.autoTgt), dat_i, sel_i));
        default: st_d.autoTgt = st_q.autoTgt;
      endcase
    end
    // Derived settings kept in flops so the pixel path stays short
    st_d.gainIdx  = 7'(int'(st_d.gainCode) / GAIN_STEP);
    st_d.blackLsb = 11'((int'($signed(st_d.blackCode)) * int'(PIX_MAX)) / BLACK_FULL);
    st_d.gammaIdx = 4'((int'(st_d.gammaCode) - GAMMA_MIN + GAMMA_STEP / 2) / GAMMA_STEP);
    // Light metering on gained pixels: count brighter minus darker
    if (adv && srcV) begin
      if (gained > st_q.autoTgt) begin
        st_d.balance = st_q.balance + 24'sd1;
      end else if (gained < st_q.autoTgt) begin
        st_d.balance = st_q.balance - 24'sd1;
      end
      // Frame end: the last pixel is counted too, then in automatic mode one quarter-decibel step
      if (srcLast) begin
        if (autoStep && st_d.balance > 0 && st_q.autoIdx != '0) begin
          st_d.autoIdx = st_q.autoIdx - 7'd1;
        end else if (autoStep && st_d.balance < 0 && st_q.autoIdx < 7'(GAIN_IDX_MAX)) begin
          st_d.autoIdx = st_q.autoIdx + 7'd1;
        end
        st_d.balance = '0;
      end
    end
    // Input skid: one entry keeps the ready output registered
    if (adv) begin
      st_d.s1V   = srcV;
      st_d.s1Pix = gained;
      st_d.holdV = 1'b0;
    end else if (pixInValid && st_q.inRdy) begin
      st_d.holdV    = 1'b1;
      st_d.holdPix  = pixInData;
      st_d.holdLast = pixInLast;
    end
    st_d.inRdy = !st_d.holdV;
    if (adv) begin
      // Offset stage; a negative offset may never reach full scale
      offs = 12'($signed({2'b00, st_q.s1Pix})) + 12'(st_q.blackLsb);
      st_d.s2V   = st_q.s1V;
      // Sum stays below 2048, so the bit above the pixel width flags overflow
      st_d.s2Pix = (offs < 0) ? '0 : (offs[PIX_W] ? PIX_MAX : offs[9:0]);
      // Gamma stage: linear interpolation between curve points
      seg    = st_q.s2Pix[9:SEG_BITS];
      lo     = gammaRom[st_q.gammaIdx][seg];
      hi     = gammaRom[st_q.gammaIdx][7'(seg) + 7'd1];
      interp = 15'(lo) + 15'(((hi - lo) * st_q.s2Pix[SEG_BITS-1:0]) >> SEG_BITS);
      st_d.s3V   = st_q.s2V;
      st_d.s3Pix = (interp > 15'(PIX_MAX)) ? PIX_MAX : interp[9:0];
      // Lookup stage; the table read runs beside this flop
      st_d.s4V   = st_q.s3V;
      st_d.s4Pix = st_q.s3Pix;
      st_d.s4Use = st_q.lutEn;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      st_q           <= '0;
      st_q.gainCode  <= GAIN_RST;
      st_q.blackCode <= BLACK_RST;
      st_q.gammaCode <= GAMMA_RST;
      st_q.gammaIdx  <= 4'(GAMMA_N - 1);
      st_q.lutIdx    <= LUT_RST;
      st_q.lutVal    <= LUT_RST;
      st_q.autoTgt   <= AUTO_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------
  // Lookup memory: no reset, contents are software's to load
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (lutWr) lutMem[st_q.lutIdx] <= st_d.lutVal;
    if (adv) lutRd_q <= lutMem[st_q.s3Pix];
  end

  // ----------------------------------------
  // Output FIFO
  // ----------------------------------------
  pxp_fifo #(
    .W     (PIX_W),
    .DEPTH (FIFO_DEPTH)
  ) uFifo (
    .clk      (clk),
    .rstn     (rstSync_n),
    .inValid  (st_q.s4V),
    .inReady  (fifoRdy),
    .inData   (s4Out),
    .outValid (pixOutValid),
    .outReady (pixOutReady),
    .outData  (pixOutData)
  );

  assign ack_o      = st_q.ack;
  assign dat_o      = st_q.rdat;
  assign pixInReady = st_q.inRdy;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_gainWrite;
    (wr && adr_i == REG_GAIN && sel_i[1:0] == 2'b11 && dat_i[15:0] <= GAIN_MAX)
    |=> st_q.gainCode == $past(dat_i[15:0]) && st_q.gainCode <= GAIN_MAX;
  endproperty
  a_gainWrite: assert property (p_gainWrite) else $error("gain setting not stored");
  property p_manualIgnored;
    (st_q.autoMode && wr && adr_i == REG_GAIN && !autoStep) |=> $stable(appliedIdx);
  endproperty
  a_manualIgnored: assert property (p_manualIgnored) else $error("manual gain leaked");
  property p_unityGain;
    (adv && srcV && appliedIdx == '0) |=> st_q.s1Pix == $past(srcPix);
  endproperty
  a_unityGain: assert property (p_unityGain) else $error("0 dB changed pixel");
  property p_modeOff;
    (wr && adr_i == REG_CTRL && sel_i[0] && !dat_i[CTRL_AUTO_BIT])
    |=> !st_q.autoMode ##1 (appliedIdx == st_q.gainIdx);
  endproperty
  a_modeOff: assert property (p_modeOff) else $error("manual mode not taken");
  property p_autoDown;
    (autoStep && st_q.balance >= 0 && gained > st_q.autoTgt && st_q.autoIdx != '0)
    |=> st_q.autoIdx == $past(st_q.autoIdx) - 7'd1;
  endproperty
  a_autoDown: assert property (p_autoDown) else $error("auto gain did not step");
  property p_autoUp;
    (autoStep && st_q.balance <= 0 && gained < st_q.autoTgt && st_q.autoIdx < 7'(GAIN_IDX_MAX))
    |=> st_q.autoIdx == $past(st_q.autoIdx) + 7'd1;
  endproperty
  a_autoUp: assert property (p_autoUp) else $error("auto gain did not rise");
  property p_blackSpan;
    $signed(st_q.blackCode) >= 16'(BLACK_MIN) && $signed(st_q.blackCode) <= 16'(BLACK_MAX);
  endproperty
  a_blackSpan: assert property (p_blackSpan) else $error("black offset out of span");
  property p_gammaUnity;
    (adv && st_q.s2V && st_q.gammaIdx == 4'(GAMMA_N - 1)) |=> st_q.s3Pix == $past(st_q.s2Pix);
  endproperty
  a_gammaUnity: assert property (p_gammaUnity) else $error("gamma 1.00 not identity");
  property p_lookupPass;
    (adv && st_q.s3V && !st_q.lutEn) |=> s4Out == $past(st_q.s3Pix);
  endproperty
  a_lookupPass: assert property (p_lookupPass) else $error("bypass changed pixel");
  property p_compRead;
    (cyc_i && stb_i && !we_i && !st_q.ack && adr_i == REG_COMP)
    |=> ack_o && dat_o[COMP_LUT_POS +: 4] == COMP_LUMA && dat_o[COMP_GAIN_POS +: 4] == COMP_LUMA;
  endproperty
  a_compRead: assert property (p_compRead) else $error("component not luminance");
  property p_offsetClamp;
    (adv && st_q.s1V && st_q.s1Pix == PIX_MAX && st_q.blackLsb >= 0)
    |=> st_q.s2Pix == PIX_MAX;
  endproperty
  a_offsetClamp: assert property (p_offsetClamp) else $error("offset not clamped");
endmodule

// ---- inc/pxp_pkg.sv ----
// Constants, register map and field layout of the pixel level pipeline.
// Assumes 10-bit luminance pixels and a 32-bit classic Wishbone slave.
package pxp_pkg;
  // ----------------------------------------
  // Pixel format
  // ----------------------------------------
  localparam int          PIX_W   = 10;
  localparam logic [9:0]  PIX_MAX = 10'h3FF;
  // ----------------------------------------
  // Register byte addresses
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_GAIN    = 8'h04;
  localparam logic [7:0] REG_BLACK   = 8'h08;
  localparam logic [7:0] REG_GAMMA   = 8'h0C;
  localparam logic [7:0] REG_LUT_IDX = 8'h10;
  localparam logic [7:0] REG_LUT_VAL = 8'h14;
  localparam logic [7:0] REG_COMP    = 8'h18;
  localparam logic [7:0] REG_STATUS  = 8'h1C;
  localparam logic [7:0] REG_AUTO    = 8'h20;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTRL_AUTO_BIT  = 0;
  localparam int CTRL_LUT_BIT   = 1;
  localparam int STAT_AUTO_BIT  = 8;
  localparam int COMP_GAIN_POS  = 0;
  localparam int COMP_OFFS_POS  = 4;
  localparam int COMP_LUT_POS   = 8;
  localparam logic [3:0] COMP_LUMA = 4'h1;
  // ----------------------------------------
  // Gain: 0.01 dB units, table in 0.25 dB steps, factor in Q8
  // ----------------------------------------
  localparam logic [15:0] GAIN_MAX     = 16'h0708;
  localparam logic [15:0] GAIN_RST     = 16'h0000;
  localparam int          GAIN_STEP    = 25;
  localparam int          GAIN_IDX_MAX = 72;
  localparam int          GAIN_FRAC    = 8;
  localparam real         DB_PER_POW   = 20.0;
  localparam real         CENTI        = 100.0;
  // ----------------------------------------
  // Black level: 0.01 % units, 10000 is white saturation
  // ----------------------------------------
  localparam int BLACK_MIN  = -500;
  localparam int BLACK_MAX  = 2500;
  localparam logic [15:0] BLACK_RST = 16'h0000;
  localparam int BLACK_FULL = 10000;
  // ----------------------------------------
  // Gamma: 0.01 units, curves in steps of 0.05, 64 segments
  // ----------------------------------------
  localparam int GAMMA_MIN  = 45;
  localparam int GAMMA_MAX  = 100;
  localparam logic [15:0] GAMMA_RST = 16'h0064;
  localparam int GAMMA_STEP = 5;
  localparam int GAMMA_N    = 12;
  localparam int SEG_BITS   = 4;
  localparam int SEGS       = 64;
  // ----------------------------------------
  // Lookup table and automatic gain
  // ----------------------------------------
  localparam int         LUT_DEPTH = 1024;
  localparam logic [9:0] LUT_RST   = 10'h000;
  localparam logic [9:0] AUTO_RST  = 10'h200;
endpackage

// ---- hw/pxp_fifo.sv ----
// Shift-register FIFO with valid/ready on both sides.
// Assumes one clock and an already synchronised active-low reset.
`timescale 1ns/1ns
module pxp_fifo #(
  parameter int W     = 10,
  parameter int DEPTH = 4
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         inValid,
  output logic              inReady,
  input  wire logic [W-1:0] inData,
  output logic              outValid,
  input  wire logic         outReady,
  output logic [W-1:0]      outData
);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] data;
    logic [DEPTH-1:0]        vld;
  } pxpFifo_t;

  pxpFifo_t st_q;
  pxpFifo_t st_d;

  // ----------------------------------------
  // Next state: head always at entry 0
  // ----------------------------------------
  always_comb begin
    logic placed;
    placed = 1'b0;
    st_d   = st_q;
    // Pop shifts everything one place toward the head
    if (st_q.vld[0] && outReady) begin
      for (int i = 0; i < DEPTH; i++) begin
        st_d.data[i] = (i < DEPTH-1) ? st_q.data[i+1] : st_q.data[i];
        st_d.vld[i]  = (i < DEPTH-1) ? st_q.vld[i+1]  : 1'b0;
      end
    end
    // Push lands in the first free slot after any pop
    if (inValid && !st_q.vld[DEPTH-1]) begin
      for (int i = 0; i < DEPTH; i++) begin
        if (!st_d.vld[i] && !placed) begin
          st_d.data[i] = inData;
          st_d.vld[i]  = 1'b1;
          placed       = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Full is judged before a pop so ready never depends on outReady
  assign inReady  = !st_q.vld[DEPTH-1];
  assign outValid = st_q.vld[0];
  assign outData  = st_q.data[0];
endmodule

// ---- verif/pxp_stream_model.sv ----
// Sensor readout source and image transport sink for the pixel pipeline.
// Assumes the bench calls push and pop; with no pop pending the sink stalls.
`timescale 1ns/1ns
module pxp_stream_model (
  input  wire logic       clk,
  input  wire logic       pixInReady,
  input  wire logic       pixOutValid,
  input  wire logic [9:0] pixOutData,
  output logic            pixInValid,
  output logic [9:0]      pixInData,
  output logic            pixInLast,
  output logic            pixOutReady
);
  // ----------------------------------------
  // Source and sink
  // ----------------------------------------
  initial begin
    pixInValid  = 1'b0;
    pixInData   = 10'h000;
    pixInLast   = 1'b0;
    pixOutReady = 1'b0;
  end

  // Held until ready is seen; afterwards the inverse shows, so stale data never matches
  task automatic push(input logic [9:0] v, input logic last);
    @(posedge clk);
    pixInValid <= 1'b1;
    pixInData  <= v;
    pixInLast  <= last;
    do @(posedge clk); while (pixInReady !== 1'b1);
    pixInValid <= 1'b0;
    pixInData  <= ~v;
    pixInLast  <= 1'b0;
  endtask

  // Ready only while a pop waits, like a transport that is often busy
  task automatic pop(output logic [9:0] v);
    @(posedge clk);
    pixOutReady <= 1'b1;
    do @(posedge clk); while (pixOutValid !== 1'b1);
    v = pixOutData;
    pixOutReady <= 1'b0;
  endtask
endmodule

// ---- verif/pxp_top_tb.sv ----
// Self-checking bench: Wishbone register access plus pixels through the chain.
// Assumes pxp_top with its default FIFO depth and the stream model beside it.
`timescale 1ns/1ns
module pxp_top_tb;
  import pxp_pkg::*;
  logic        clk, rstn, cyc, stb, we, ack;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] datW, datR;
  logic        inV, inR, inL, outV, outR;
  logic [9:0]  inD, outD, got;
  int          n_fail, cmp_count, cycles;

  pxp_top dut_u (.clk(clk), .rstn(rstn), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(datW), .dat_o(datR), .ack_o(ack),
    .pixInValid(inV), .pixInReady(inR), .pixInData(inD), .pixInLast(inL),
    .pixOutValid(outV), .pixOutReady(outR), .pixOutData(outD));
  pxp_stream_model sm_u (.clk(clk), .pixInReady(inR), .pixOutValid(outV),
    .pixOutData(outD), .pixInValid(inV), .pixInData(inD), .pixInLast(inL),
    .pixOutReady(outR));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic final_report();
    if (n_fail == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // One classic cycle; data is taken for the edge at which ack is high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    datW <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = datR;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask

  task automatic pix(input logic [9:0] v, input logic [9:0] e, input logic last);
    logic [9:0] q;
    sm_u.push(v, last);
    sm_u.pop(q);
    chk({22'h0, q}, {22'h0, e});
  endtask

  // Hang guard: the whole sequence needs well under 3000 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      n_fail++;
      final_report();
    end
  end

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {cyc, stb, we, adr, datW} = '0;
    sel = 4'hF;
    rstn = 1'b0;
    n_fail = 0;
    cmp_count = 0;
    cycles = 0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    rd(REG_CTRL, 32'h0);
    rd(REG_GAIN, 32'h0);
    rd(REG_BLACK, 32'h0);
    rd(REG_GAMMA, 32'h64);
    rd(REG_LUT_IDX, 32'h0);
    rd(REG_LUT_VAL, 32'h0);
    rd(8'h24, 32'h0);
    wr(REG_COMP, 32'h0);
    rd(REG_COMP, 32'h111);
    pix(10'h000, 10'h000, 1'b0);
    pix(10'h2AA, 10'h2AA, 1'b0);
    pix(10'h3FF, 10'h3FF, 1'b0);
    wr(REG_GAIN, 32'h1000);
    rd(REG_GAIN, 32'h708);
    // Frame closed in manual mode so the automatic frame meters one pixel
    pix(10'h100, 10'h3FF, 1'b1);
    wr(REG_CTRL, 32'h1);
    pix(10'h100, 10'h100, 1'b1);
    wr(REG_GAIN, 32'h0);
    rd(REG_STATUS, 32'h101);
    wr(REG_CTRL, 32'h0);
    wr(REG_BLACK, 32'h9C4);
    pix(10'h000, 10'h0FF, 1'b0);
    wr(REG_BLACK, 32'hFE0C);
    rd(REG_BLACK, 32'hFFFFFE0C);
    pix(10'h3FF, 10'h3CC, 1'b0);
    pix(10'h010, 10'h000, 1'b0);
    wr(REG_BLACK, 32'h0);
    wr(REG_LUT_IDX, 32'h5);
    wr(REG_LUT_VAL, 32'h3AB);
    wr(REG_LUT_IDX, 32'h3FF);
    wr(REG_LUT_VAL, 32'h11);
    rd(REG_LUT_VAL, 32'h11);
    wr(REG_CTRL, 32'h2);
    pix(10'h005, 10'h3AB, 1'b0);
    pix(10'h3FF, 10'h011, 1'b0);
    wr(REG_CTRL, 32'h0);
    pix(10'h005, 10'h005, 1'b0);
    // Sink stalls while a burst arrives: FIFO fills, then input is refused
    fork
      for (int k = 0; k < 16; k++) sm_u.push(10'(k * 3), 1'b0);
    join_none
    repeat (80) @(posedge clk);
    @(negedge clk);
    chk({31'h0, inR}, 32'h0);
    for (int k = 0; k < 16; k++) begin
      sm_u.pop(got);
      chk({22'h0, got}, 32'(k * 3));
    end
    final_report();
  end
endmodule
